//--- verilog/pdlm_pkg.sv
package pdlm_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [15:0] PDLM_OFF_SLEEP = 16'h0a00;
  localparam logic [15:0] PDLM_OFF_LOOP = 16'h0a01;
  localparam logic [15:0] PDLM_OFF_REFSTAT = 16'h0a10;
  localparam logic [17:0] PDLM_ADDR_SLEEP = 18'h0_2800;
  localparam logic [17:0] PDLM_ADDR_LOOP = 18'h0_2804;
  localparam logic [17:0] PDLM_ADDR_STAT = 18'h0_2840;
  localparam logic [7:0] PDLM_SLEEP_RST = 8'h00;
  localparam logic [7:0] PDLM_LOOP_RST = 8'h00;
  // ****************************************
  // Sleep register fields
  // ****************************************
  localparam int PDLM_BIT_FULL = 0;
  localparam int PDLM_BIT_DIST = 1;
  localparam int PDLM_BIT_DAC = 2;
  localparam int PDLM_BIT_TDC = 3;
  localparam int PDLM_BIT_REF = 4;
  localparam int PDLM_BIT_SYSCLK = 5;
  localparam int PDLM_BIT_SOFTRST = 7;
  localparam logic [7:0] PDLM_SLEEP_MASK = 8'hbf;
  // ****************************************
  // Loop mode fields
  // ****************************************
  localparam int PDLM_BIT_PREF_LO = 0;
  localparam int PDLM_BIT_POL_LO = 3;
  localparam int PDLM_BIT_FREERUN = 5;
  localparam int PDLM_BIT_HOLDOVER = 6;
  localparam logic [7:0] PDLM_LOOP_MASK = 8'h7b;
  localparam int PDLM_NREF = 4;
  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    PDLM_POL_AUTO = 2'h0,
    PDLM_POL_FALLBACK = 2'h1,
    PDLM_POL_HOLDOVER = 2'h2,
    PDLM_POL_MANUAL = 2'h3
  } pdlm_policy_t;
  typedef enum logic [1:0] {
    PDLM_REF_A = 2'h0,
    PDLM_REF_AA = 2'h1,
    PDLM_REF_B = 2'h2,
    PDLM_REF_BB = 2'h3
  } pdlm_ref_t;
  typedef enum logic [1:0] {
    PDLM_LOOP_LOCKED = 2'h0,
    PDLM_LOOP_HOLDOVER = 2'h1,
    PDLM_LOOP_FREERUN = 2'h2
  } pdlm_loop_t;
  localparam logic [1:0] PDLM_HTRANS_NONSEQ = 2'h2;
endpackage

//--- verilog/pdlm_refsel.sv
`timescale 1ns/1ps
module pdlm_refsel (
  // Policy
  input wire logic [1:0] policy,
  input wire logic [1:0] pref,
  input wire logic [3:0] ref_valid,
  input wire logic [3:0] ref_prio_first,
  input wire logic force_holdover,
  input wire logic force_freerun,
  // Result
  output logic [1:0] sel_ref,
  output logic [1:0] loop_state
);
  import pdlm_pkg::*;
  logic [1:0] auto_ref;
  logic auto_ok;
  logic pref_ok;
  // ****************************************
  // Automatic pick: lowest valid index among ref_prio_first refs, else lowest valid index of the rest
  // ****************************************
  always_comb begin
    auto_ref = 2'h0;
    auto_ok = 1'b0;
    for (int i = PDLM_NREF - 1; i >= 0; i--) begin
      if (ref_valid[i] && ref_prio_first[i] == 1'b0) begin
        auto_ref = 2'(i);
        auto_ok = 1'b1;
      end
    end
    for (int i = PDLM_NREF - 1; i >= 0; i--) begin
      if (ref_valid[i] && ref_prio_first[i]) begin
        auto_ref = 2'(i);
        auto_ok = 1'b1;
      end
    end
  end
  assign pref_ok = ref_valid[pref];
  // ****************************************
  // Policy decision
  // ****************************************
  always_comb begin
    sel_ref = auto_ref;
    loop_state = auto_ok ? PDLM_LOOP_LOCKED : PDLM_LOOP_HOLDOVER;
    unique case (policy)
      PDLM_POL_AUTO: begin
        sel_ref = auto_ref;
      end
      PDLM_POL_FALLBACK: begin
        sel_ref = pref_ok ? pref : auto_ref;
        loop_state = (pref_ok || auto_ok) ? PDLM_LOOP_LOCKED
                                          : PDLM_LOOP_HOLDOVER;
      end
      PDLM_POL_HOLDOVER: begin
        sel_ref = pref;
        loop_state = pref_ok ? PDLM_LOOP_LOCKED : PDLM_LOOP_HOLDOVER;
      end
      PDLM_POL_MANUAL: begin
        sel_ref = pref;
        loop_state = PDLM_LOOP_LOCKED;
      end
    endcase
    if (force_holdover) begin
      loop_state = PDLM_LOOP_HOLDOVER;
    end
    if (force_freerun) begin
      loop_state = PDLM_LOOP_FREERUN;
    end
  end
endmodule

//--- verilog/pdlm_top.sv
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module pdlm_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [17:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Reference health from pins
  input wire logic [3:0] ref_valid_pin,
  input wire logic [3:0] ref_prio_first,
  // Stored free-run and loop tuning words
  input wire logic [47:0] freerun_word,
  input wire logic [47:0] loop_word,
  // Sleep controls
  output logic ref_sleep,
  output logic time_converter_sleep,
  output logic dac_sleep,
  output logic dist_sleep,
  output logic chip_sleep,
  output logic system_clock_sleep,
  output logic core_reset,
  // Loop controls
  output logic [1:0] active_ref,
  output logic [1:0] loop_state,
  output logic [47:0] tuning_word
);
  import pdlm_pkg::*;
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] sleep_r;
  logic [7:0] loop_r;
  logic [3:0] valid_meta_r;
  logic [3:0] valid_r;
  logic wr_pend_r;
  logic [17:0] wr_addr_r;
  logic [1:0] sel_ref;
  logic [1:0] sel_state;
  logic [31:0] rd_nxt;
  logic take;
  assign take = hsel && hready && htrans == PDLM_HTRANS_NONSEQ;
  // ****************************************
  // Pin synchroniser
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_meta_r <= 4'h0;
      valid_r <= 4'h0;
    end else begin
      valid_meta_r <= ref_valid_pin;
      valid_r <= valid_meta_r;
    end
  end
  // ****************************************
  // Bus address phase capture
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 18'h0_0000;
    end else if (hready) begin
      wr_pend_r <= take && hwrite;
      wr_addr_r <= haddr;
    end
  end
  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_r <= PDLM_SLEEP_RST;
    end else if (wr_pend_r && wr_addr_r == PDLM_ADDR_SLEEP) begin
      sleep_r <= hwdata[7:0] & PDLM_SLEEP_MASK;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      loop_r <= PDLM_LOOP_RST;
    end else if (wr_pend_r && wr_addr_r == PDLM_ADDR_LOOP) begin
      loop_r <= hwdata[7:0] & PDLM_LOOP_MASK;
    end
  end
  // ****************************************
  // Read data
  // ****************************************
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (haddr == PDLM_ADDR_SLEEP) begin
      rd_nxt = {24'h00_0000, sleep_r};
    end else if (haddr == PDLM_ADDR_LOOP) begin
      rd_nxt = {24'h00_0000, loop_r};
    end else if (haddr == PDLM_ADDR_STAT) begin
      rd_nxt = {24'h00_0000, valid_r, sel_state, active_ref};
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= rd_nxt;
      end
    end
  end
  // ****************************************
  // Reference selection
  // ****************************************
  pdlm_refsel u_refsel (
    .policy(loop_r[PDLM_BIT_POL_LO +: 2]),
    .pref(loop_r[PDLM_BIT_PREF_LO +: 2]),
    .ref_valid(valid_r),
    .ref_prio_first(ref_prio_first),
    .force_holdover(loop_r[PDLM_BIT_HOLDOVER]),
    .force_freerun(loop_r[PDLM_BIT_FREERUN]),
    .sel_ref(sel_ref),
    .loop_state(sel_state)
  );
  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_sleep <= 1'b0;
      time_converter_sleep <= 1'b0;
      dac_sleep <= 1'b0;
      dist_sleep <= 1'b0;
      chip_sleep <= 1'b0;
      system_clock_sleep <= 1'b0;
      core_reset <= 1'b0;
    end else begin
      ref_sleep <= sleep_r[PDLM_BIT_REF];
      time_converter_sleep <= sleep_r[PDLM_BIT_TDC];
      dac_sleep <= sleep_r[PDLM_BIT_DAC];
      dist_sleep <= sleep_r[PDLM_BIT_DIST];
      chip_sleep <= sleep_r[PDLM_BIT_FULL];
      system_clock_sleep <= sleep_r[PDLM_BIT_SYSCLK];
      core_reset <= sleep_r[PDLM_BIT_SOFTRST];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_ref <= 2'h0;
      loop_state <= 2'h0;
      tuning_word <= 48'h0000_0000_0000;
    end else if (sleep_r[PDLM_BIT_SOFTRST]) begin
      active_ref <= 2'h0;
      loop_state <= 2'h0;
      tuning_word <= 48'h0000_0000_0000;
    end else begin
      active_ref <= sel_ref;
      loop_state <= sel_state;
      if (sel_state == PDLM_LOOP_FREERUN) begin
        tuning_word <= freerun_word;
      end else if (sel_state == PDLM_LOOP_LOCKED) begin
        tuning_word <= loop_word;
      end
    end
  end
endmodule

//--- bench/pdlm_monitor.sv
`timescale 1ns/1ps
module pdlm_monitor (
  // Bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [17:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Controls
  input wire logic [3:0] ref_valid_pin,
  input wire logic [47:0] freerun_word,
  input wire logic ref_sleep,
  input wire logic time_converter_sleep,
  input wire logic dac_sleep,
  input wire logic dist_sleep,
  input wire logic chip_sleep,
  input wire logic system_clock_sleep,
  input wire logic core_reset,
  input wire logic [1:0] active_ref,
  input wire logic [1:0] loop_state,
  input wire logic [47:0] tuning_word
);
  import pdlm_pkg::*;
  logic [3:0] ph_r;
  logic [7:0] sleep_r, loop_r;
  logic is_s, is_l;
  logic [6:0] sleeps;
  assign is_s = hsel && hready && htrans == PDLM_HTRANS_NONSEQ
    && haddr == PDLM_ADDR_SLEEP;
  assign is_l = hsel && hready && htrans == PDLM_HTRANS_NONSEQ
    && haddr == PDLM_ADDR_LOOP;
  assign sleeps = {core_reset, system_clock_sleep, ref_sleep,
    time_converter_sleep, dac_sleep, dist_sleep, chip_sleep};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 4'h0;
      sleep_r <= 8'h00;
      loop_r <= 8'h00;
    end else begin
      ph_r <= {is_s && hwrite, is_l && hwrite,
        is_s && !hwrite, is_l && !hwrite};
      if (ph_r[3]) sleep_r <= hwdata[7:0] & PDLM_SLEEP_MASK;
      if (ph_r[2]) loop_r <= hwdata[7:0] & PDLM_LOOP_MASK;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sleep_follow_a: assert property (
    ph_r[3] |-> ##2 sleeps == $past({hwdata[7], hwdata[5:0]}, 2))
    else $error("sleep outputs wrong");
  sleep_read_a: assert property (
    ph_r[1] |-> hrdata == {24'h00_0000, sleep_r})
    else $error("sleep read wrong");
  loop_read_a: assert property (
    ph_r[0] |-> hrdata == {24'h00_0000, loop_r})
    else $error("loop read wrong");
  freerun_wins_a: assert property (
    (loop_r[5] && !sleep_r[7]) [*3] |-> loop_state == PDLM_LOOP_FREERUN
    && tuning_word == freerun_word)
    else $error("free-run not taken");
  hold_forced_a: assert property (
    (loop_r[6:5] == 2'h2 && !sleep_r[7]) [*3]
    |-> loop_state == PDLM_LOOP_HOLDOVER)
    else $error("forced holdover not taken");
  manual_pref_a: assert property (
    (loop_r[6:3] == 4'h3 && !sleep_r[7] && $stable(loop_r)) [*3]
    |-> active_ref == loop_r[1:0] && loop_state == PDLM_LOOP_LOCKED)
    else $error("manual reference wrong");
  pref_lost_a: assert property (
    (loop_r[6:3] == 4'h2 && !ref_valid_pin[loop_r[1:0]] && !sleep_r[7]
    && $stable(ref_valid_pin)) [*6] |-> loop_state == PDLM_LOOP_HOLDOVER)
    else $error("lost preferred not holdover");
  soft_reset_a: assert property (
    core_reset [*2] |-> loop_state == 2'h0 && active_ref == 2'h0
    && tuning_word == 48'h0000_0000_0000)
    else $error("soft reset not clearing");
endmodule
bind pdlm_top pdlm_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .ref_valid_pin(ref_valid_pin), .freerun_word(freerun_word),
  .ref_sleep(ref_sleep), .time_converter_sleep(time_converter_sleep),
  .dac_sleep(dac_sleep), .dist_sleep(dist_sleep), .chip_sleep(chip_sleep),
  .system_clock_sleep(system_clock_sleep), .core_reset(core_reset),
  .active_ref(active_ref), .loop_state(loop_state),
  .tuning_word(tuning_word));

//--- bench/test_power_down_and_loop_mode_control.sv
`timescale 1ns/1ps
module test_power_down_and_loop_mode_control;
  import pdlm_pkg::*;
  typedef struct packed {
    logic [7:0] s;
    logic [7:0] l;
    logic [3:0] v;
    logic [1:0] st;
    logic [1:0] r;
  } pdlm_row_t;
  localparam logic [47:0] FW = 48'h0123_4567_89ab;
  localparam logic [47:0] LW = 48'h0fed_cba9_8765;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [17:0] haddr = 18'h0_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] ref_valid_pin = 4'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, ref_sleep, time_converter_sleep, dac_sleep;
  logic dist_sleep, chip_sleep, system_clock_sleep, core_reset;
  logic [1:0] active_ref, loop_state;
  logic [47:0] tuning_word;
  logic [6:0] sleeps;
  pdlm_row_t r;
  int mismatches = 0;
  int checks = 0;
  pdlm_row_t rows [11] = '{
    '{8'h01, 8'h00, 4'hf, 2'h0, 2'h3}, '{8'h02, 8'h84, 4'h6, 2'h0, 2'h1},
    '{8'h04, 8'h0a, 4'h6, 2'h0, 2'h2}, '{8'h08, 8'h08, 4'h6, 2'h0, 2'h1},
    '{8'h10, 8'h11, 4'h6, 2'h0, 2'h1}, '{8'h20, 8'h10, 4'h6, 2'h1, 2'h0},
    '{8'h40, 8'h1b, 4'h0, 2'h0, 2'h3}, '{8'h00, 8'h40, 4'hf, 2'h1, 2'h0},
    '{8'h00, 8'h60, 4'hf, 2'h2, 2'h0}, '{8'h00, 8'h00, 4'h0, 2'h1, 2'h0},
    '{8'h00, 8'h20, 4'hf, 2'h2, 2'h0}};
  always #2.5 hclk = ~hclk;
  assign sleeps = {core_reset, system_clock_sleep, ref_sleep,
    time_converter_sleep, dac_sleep, dist_sleep, chip_sleep};
  pdlm_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ref_valid_pin(ref_valid_pin), .ref_prio_first(4'h8),
    .freerun_word(FW), .loop_word(LW), .ref_sleep(ref_sleep),
    .time_converter_sleep(time_converter_sleep), .dac_sleep(dac_sleep),
    .dist_sleep(dist_sleep), .chip_sleep(chip_sleep),
    .system_clock_sleep(system_clock_sleep), .core_reset(core_reset),
    .active_ref(active_ref), .loop_state(loop_state),
    .tuning_word(tuning_word));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic wait_rdy();
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic w, input logic [17:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PDLM_HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      bus(1'b1, PDLM_ADDR_SLEEP, {24'h00_0000, r.s}, rd);
      bus(1'b1, PDLM_ADDR_LOOP, {24'h00_0000, r.l}, rd);
      ref_valid_pin <= r.v;
      repeat (8) @(posedge hclk);
      chk(sleeps, {r.s[7], r.s[5:0]});
      chk(loop_state, r.st);
      if (r.st == 2'h0) chk(active_ref, r.r);
      if (r.st != 2'h1) chk(tuning_word, r.st[1] ? FW : LW);
      bus(1'b0, PDLM_ADDR_SLEEP, 32'h0000_0000, rd);
      chk(rd, {24'h00_0000, r.s & PDLM_SLEEP_MASK});
      bus(1'b0, PDLM_ADDR_LOOP, 32'h0000_0000, rd);
      chk(rd, {24'h00_0000, r.l & PDLM_LOOP_MASK});
    end
    $display("table cases done");
    bus(1'b1, PDLM_ADDR_SLEEP, 32'h0000_0080, rd);
    repeat (4) @(posedge hclk);
    chk(loop_state, 2'h0);
    chk(tuning_word, 48'h0000_0000_0000);
    bus(1'b0, PDLM_ADDR_LOOP, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0020);
    bus(1'b1, PDLM_ADDR_SLEEP, 32'h0000_0000, rd);
    repeat (6) @(posedge hclk);
    chk(loop_state, PDLM_LOOP_FREERUN);
    $display("soft reset done");
    bus(1'b1, 18'h0_3000, 32'h0000_00ff, rd);
    bus(1'b0, 18'h0_3000, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'b0, PDLM_ADDR_LOOP, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0020);
    bus(1'b0, PDLM_ADDR_STAT, 32'h0000_0000, rd);
    chk(rd, 32'h0000_00fb);
    $display("unmapped access done");
    bus(1'b1, PDLM_ADDR_SLEEP, 32'h0000_003f, rd);
    repeat (4) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(sleeps, 7'h00);
    chk(loop_state, 2'h0);
    hresetn <= 1'b1;
    bus(1'b0, PDLM_ADDR_SLEEP, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    bus(1'b0, PDLM_ADDR_LOOP, 32'h0000_0000, rd);
    chk(rd, 32'h0000_0000);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
